// ---- hdl/dma_cfg_pkg.sv ----
// Constants for the channel-3 register slots and counter layout.
// Assumes byte addresses on a 10-bit register port, 32-bit data.
package dma_cfg_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [9:0] OFS_CH2_VEC = 10'h394;
  localparam logic [9:0] OFS_SRC = 10'h3C0;
  localparam logic [9:0] OFS_DST = 10'h3C4;
  localparam logic [9:0] OFS_CTRL = 10'h3C8;
  localparam logic [9:0] OFS_COUNT = 10'h3CC;
  localparam logic [9:0] OFS_STAT = 10'h3D0;
  localparam logic [9:0] OFS_VEC = 10'h3D4;
  localparam logic [9:0] OFS_PARK = 10'h00C;
  // ==========================================================
  // Field positions
  localparam int PARK_WIDE_BIT = 0;
  localparam int CTRL_AT_BIT = 15;
  localparam int CTRL_START_BIT = 16;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int LEGACY_POS = 16;
  // ==========================================================
  // Counter widths and masks
  localparam int LEGACY_W = 16;
  localparam int WIDE_W = 24;
  localparam logic [23:0] LEGACY_MASK = 24'h00FFFF;
  localparam logic [23:0] WIDE_MASK = 24'hFFFFFF;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_COUNT = 24'h000000;
  // ==========================================================
  // Channel states
  typedef enum logic {ST_IDLE, ST_RUN} chan_state_t;
endpackage

// ---- hdl/byte_counter.sv ----
// Transfer byte counter, 16 or 24 bits wide.
// Assumes load and dec never matter together: load wins.
`timescale 1ns/1ps
module byte_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic wide,
  input wire logic load,
  input wire logic [23:0] load_val,
  input wire logic dec,
  // State
  output logic [23:0] count,
  output logic last
);
  typedef struct packed {
    logic [23:0] cnt;
  } cnt_state_t;
  cnt_state_t s_reg, s_next;
  logic [23:0] mask;

  always_comb begin
    mask = wide ? dma_cfg_pkg::WIDE_MASK : dma_cfg_pkg::LEGACY_MASK;
    s_next = s_reg;
    if (load) begin
      s_next.cnt = load_val & mask;
    end else if (dec) begin
      s_next.cnt = (s_reg.cnt - 24'h000001) & mask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_reg <= '{cnt: dma_cfg_pkg::RST_COUNT};
    end else begin
      s_reg <= s_next;
    end
  end

  // Old upper bits are hidden in legacy mode, never counted
  assign count = s_reg.cnt & mask;
  assign last = (count == 24'h000001);

  a_dec_legacy: assert property (@(posedge core_clk)
    disable iff (!rstn)
    dec && !load && !wide && $stable(wide) |=>
      count == (($past(count) - 24'h000001) & dma_cfg_pkg::LEGACY_MASK))
    else $error("legacy count step wrong");
  a_dec_wide: assert property (@(posedge core_clk)
    disable iff (!rstn)
    dec && !load && wide && $stable(wide) |=>
      count == $past(count) - 24'h000001)
    else $error("wide count step wrong");
endmodule

// ---- hdl/ack_gen.sv ----
// Registered transfer acknowledge toward the peripheral.
// Assumes xfer marks one transfer per cycle.
`timescale 1ns/1ps
module ack_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Transfer events
  input wire logic xfer,
  input wire logic final_xfer,
  input wire logic at_eff,
  // Peripheral side
  output logic ack
);
  typedef struct packed {
    logic ack;
  } ack_state_t;
  ack_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    // Every transfer, or only the final one
    s_next.ack = xfer && (!at_eff || final_xfer);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_reg <= '{ack: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ack = s_reg.ack;

  a_ack_every: assert property (@(posedge core_clk)
    disable iff (!rstn)
    xfer && !at_eff |=> ack)
    else $error("ack missing for transfer");
  a_ack_final_only: assert property (@(posedge core_clk)
    disable iff (!rstn)
    at_eff && !(xfer && final_xfer) |=> !ack)
    else $error("ack outside final transfer");
endmodule

// ---- hdl/dma_byte_count_config.sv ----
// Channel-3 DMA register slots, channel-2 vector slot, and the
// 16/24-bit byte counter layout select with a small transfer engine.
// Assumes a plain register port, read data one cycle after the strobe,
// and a peripheral request level synchronous to core_clk.
`timescale 1ns/1ps
module dma_byte_count_config (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [9:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Peripheral link
  input wire logic dma_req,
  output logic dma_ack,
  // Status
  output logic wide_counter_select,
  output logic chan_busy,
  output logic chan_done
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] ctrl;
    logic [7:0] vec2;
    logic [7:0] vec3;
    logic [7:0] park;
    logic done;
    dma_cfg_pkg::chan_state_t st;
    logic [31:0] rd_data;
  } regs_t;

  regs_t s_reg, s_next;

  // ==========================================================
  // Decode
  logic hit_src, hit_dst, hit_ctrl, hit_count;
  logic hit_stat, hit_vec3, hit_vec2, hit_park;

  always_comb begin
    hit_src = 1'b0;
    hit_dst = 1'b0;
    hit_ctrl = 1'b0;
    hit_count = 1'b0;
    hit_stat = 1'b0;
    hit_vec3 = 1'b0;
    hit_vec2 = 1'b0;
    hit_park = 1'b0;
    if (addr == dma_cfg_pkg::OFS_SRC) begin
      hit_src = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_DST) begin
      hit_dst = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_COUNT) begin
      hit_count = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_STAT) begin
      hit_stat = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_VEC) begin
      hit_vec3 = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_CH2_VEC) begin
      hit_vec2 = 1'b1;
    end else if (addr == dma_cfg_pkg::OFS_PARK) begin
      hit_park = 1'b1;
    end
  end

  // ==========================================================
  // Mode and counter
  logic wide;
  logic at_eff;
  logic [23:0] count;
  logic last;
  logic cnt_load;
  logic [23:0] cnt_load_val;
  logic xfer;
  logic final_xfer;
  logic start_req;
  logic running;

  // Zero in the park bit selects the legacy layout
  assign wide = s_reg.park[dma_cfg_pkg::PARK_WIDE_BIT];
  // Timing bit is ignored while the legacy layout is chosen
  assign at_eff = wide & s_reg.ctrl[dma_cfg_pkg::CTRL_AT_BIT];
  assign running = (s_reg.st == dma_cfg_pkg::ST_RUN);
  assign xfer = running && dma_req;
  assign final_xfer = xfer && last;
  assign cnt_load = wr_en && hit_count;
  assign start_req = wr_en && hit_ctrl &&
    wr_data[dma_cfg_pkg::CTRL_START_BIT];

  always_comb begin
    if (wide) begin
      cnt_load_val = wr_data[23:0];
    end else begin
      cnt_load_val = {8'h00, wr_data[31:16]};
    end
  end

  byte_counter u_count (
    .core_clk(core_clk),
    .rstn(rstn),
    .wide(wide),
    .load(cnt_load),
    .load_val(cnt_load_val),
    .dec(xfer),
    .count(count),
    .last(last)
  );

  ack_gen u_ack (
    .core_clk(core_clk),
    .rstn(rstn),
    .xfer(xfer),
    .final_xfer(final_xfer),
    .at_eff(at_eff),
    .ack(dma_ack)
  );

  // ==========================================================
  // Read mux
  logic [31:0] count_word;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  always_comb begin
    if (wide) begin
      count_word = {8'h00, count};
    end else begin
      count_word = {count[15:0], 16'h0000};
    end
    stat_word = dma_cfg_pkg::RST_WORD;
    stat_word[dma_cfg_pkg::STAT_DONE_BIT] = s_reg.done;
    stat_word[dma_cfg_pkg::STAT_BUSY_BIT] = running;
  end

  always_comb begin
    rd_mux = dma_cfg_pkg::RST_WORD;
    if (hit_src) begin
      rd_mux = s_reg.src;
    end else if (hit_dst) begin
      rd_mux = s_reg.dst;
    end else if (hit_ctrl) begin
      rd_mux = s_reg.ctrl;
    end else if (hit_count) begin
      rd_mux = count_word;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end else if (hit_vec3) begin
      rd_mux = {24'h000000, s_reg.vec3};
    end else if (hit_vec2) begin
      rd_mux = {24'h000000, s_reg.vec2};
    end else if (hit_park) begin
      rd_mux = {24'h000000, s_reg.park};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    // Read data stands for exactly one cycle after the strobe
    s_next.rd_data = rd_en ? rd_mux : dma_cfg_pkg::RST_WORD;
    if (wr_en) begin
      if (hit_src) begin
        s_next.src = wr_data;
      end else if (hit_dst) begin
        s_next.dst = wr_data;
      end else if (hit_ctrl) begin
        // Start is a command, not stored
        s_next.ctrl = wr_data;
        s_next.ctrl[dma_cfg_pkg::CTRL_START_BIT] = 1'b0;
      end else if (hit_vec3) begin
        s_next.vec3 = wr_data[7:0];
      end else if (hit_vec2) begin
        s_next.vec2 = wr_data[7:0];
      end else if (hit_park) begin
        s_next.park = wr_data[7:0];
      end
    end
    // Done clears by writing one; a finishing transfer wins
    if (wr_en && hit_stat && wr_data[dma_cfg_pkg::STAT_DONE_BIT]) begin
      s_next.done = 1'b0;
    end
    if (final_xfer) begin
      s_next.done = 1'b1;
    end
    case (s_reg.st)
      dma_cfg_pkg::ST_IDLE: begin
        // A zero count would underflow, so it never starts
        if (start_req && count != dma_cfg_pkg::RST_COUNT) begin
          s_next.st = dma_cfg_pkg::ST_RUN;
        end
      end
      dma_cfg_pkg::ST_RUN: begin
        if (final_xfer) begin
          s_next.st = dma_cfg_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = dma_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_reg.src <= dma_cfg_pkg::RST_WORD;
      s_reg.dst <= dma_cfg_pkg::RST_WORD;
      s_reg.ctrl <= dma_cfg_pkg::RST_WORD;
      s_reg.vec2 <= dma_cfg_pkg::RST_BYTE;
      s_reg.vec3 <= dma_cfg_pkg::RST_BYTE;
      s_reg.park <= dma_cfg_pkg::RST_BYTE;
      s_reg.done <= 1'b0;
      s_reg.st <= dma_cfg_pkg::ST_IDLE;
      s_reg.rd_data <= dma_cfg_pkg::RST_WORD;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign rd_data = s_reg.rd_data;
  assign wide_counter_select = s_reg.park[dma_cfg_pkg::PARK_WIDE_BIT];
  assign chan_busy = running;
  assign chan_done = s_reg.done;

  // ==========================================================
  // Checks
  // Counter layout and loads
  a_legacy_layout: assert property (@(posedge core_clk)
    disable iff (!rstn)
    rd_en && addr == dma_cfg_pkg::OFS_COUNT && !wide |=>
      rd_data[15:0] == 16'h0000)
    else $error("legacy count not in upper half");
  a_wide_layout: assert property (@(posedge core_clk)
    disable iff (!rstn)
    rd_en && addr == dma_cfg_pkg::OFS_COUNT && wide |=>
      rd_data[31:24] == 8'h00 && rd_data[23:0] == $past(count))
    else $error("wide count not in low bits");
  a_legacy_load: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_COUNT && !wide && $stable(wide)
      ##1 !xfer |=> count == {8'h00, $past(wr_data[31:16], 2)})
    else $error("legacy load wrong");
  a_wide_load: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_COUNT && wide
      ##1 !xfer && $stable(wide) |=> count == $past(wr_data[23:0], 2))
    else $error("wide load wrong");
  a_select_bit: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_PARK |=>
      wide_counter_select == $past(wr_data[dma_cfg_pkg::PARK_WIDE_BIT]))
    else $error("layout select not taken");

  // Acknowledge and channel state
  a_timing_gated: assert property (@(posedge core_clk)
    disable iff (!rstn)
    xfer && !wide |=> dma_ack)
    else $error("timing bit acted in legacy mode");
  a_final_ack: assert property (@(posedge core_clk)
    disable iff (!rstn)
    final_xfer |=> dma_ack && chan_done && !chan_busy)
    else $error("final transfer not acknowledged");
  a_idle_no_ack: assert property (@(posedge core_clk)
    disable iff (!rstn)
    !running |=> !dma_ack)
    else $error("acknowledge without a transfer");
  a_zero_start_ignored: assert property (@(posedge core_clk)
    disable iff (!rstn)
    start_req && !running && count == dma_cfg_pkg::RST_COUNT |=> !chan_busy)
    else $error("channel started with a zero count");
  a_start_runs: assert property (@(posedge core_clk)
    disable iff (!rstn)
    start_req && !running && count != dma_cfg_pkg::RST_COUNT |=> chan_busy)
    else $error("start command not taken");
  a_busy_hold: assert property (@(posedge core_clk)
    disable iff (!rstn)
    running && !final_xfer |=> chan_busy)
    else $error("channel stopped before its final transfer");
  a_done_clear: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_STAT && !final_xfer &&
      wr_data[dma_cfg_pkg::STAT_DONE_BIT] |=>
      !chan_done)
    else $error("done not cleared by a write of one");
  a_done_wins: assert property (@(posedge core_clk)
    disable iff (!rstn)
    final_xfer && wr_en && addr == dma_cfg_pkg::OFS_STAT |=> chan_done)
    else $error("done lost to a clear");

  // Register map and read port
  // Back-to-back write then read catches a slot decoded at a wrong offset
  a_map_vector: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_VEC
      ##1 rd_en && addr == dma_cfg_pkg::OFS_VEC |=>
      rd_data == {24'h000000, $past(wr_data[7:0], 2)})
    else $error("vector slot not at its offset");
  a_map_source: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_SRC
      ##1 rd_en && addr == dma_cfg_pkg::OFS_SRC |=>
      rd_data == $past(wr_data, 2))
    else $error("source slot not at its offset");
  a_map_dest: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_DST
      ##1 rd_en && addr == dma_cfg_pkg::OFS_DST |=>
      rd_data == $past(wr_data, 2))
    else $error("destination slot not at its offset");
  a_map_status: assert property (@(posedge core_clk)
    disable iff (!rstn)
    rd_en && addr == dma_cfg_pkg::OFS_STAT |=>
      rd_data[dma_cfg_pkg::STAT_DONE_BIT] == $past(chan_done) &&
      rd_data[dma_cfg_pkg::STAT_BUSY_BIT] == $past(chan_busy))
    else $error("status slot not at its offset");
  a_map_ch2_vector: assert property (@(posedge core_clk)
    disable iff (!rstn)
    wr_en && addr == dma_cfg_pkg::OFS_CH2_VEC
      ##1 rd_en && addr == dma_cfg_pkg::OFS_CH2_VEC |=>
      rd_data == {24'h000000, $past(wr_data[7:0], 2)})
    else $error("channel 2 vector slot not at its offset");
  a_read_idle_zero: assert property (@(posedge core_clk)
    disable iff (!rstn)
    !rd_en |=> rd_data == dma_cfg_pkg::RST_WORD)
    else $error("read data outside its cycle");
endmodule

// ---- tb/periph_model.sv ----
// Peripheral model: raises a transfer request and counts acknowledges.
// Assumes requests synchronous to core_clk and at most one ack a cycle.
`timescale 1ns/1ps
module periph_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench control
  input wire logic req_en,
  input wire logic slow,
  // Link
  input wire logic dma_ack,
  output logic dma_req,
  output logic [7:0] ack_count
);
  logic toggle_reg;
  // ==========================================================
  // Slow mode requests every other cycle to stall the channel
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      toggle_reg <= 1'b0;
      dma_req <= 1'b0;
      ack_count <= 8'h00;
    end else begin
      toggle_reg <= ~toggle_reg;
      dma_req <= req_en & (~slow | toggle_reg);
      if (dma_ack) begin
        ack_count <= ack_count + 8'h01;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the channel-3 register block.
// Assumes the peripheral model in periph_model.sv.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wr_data = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic dma_req, dma_ack, wide_counter_select, chan_busy, chan_done;
  logic req_en = 1'b0;
  logic slow = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] ack_count;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h00000037;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  // ==========================================================
  // Clock, timeout
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      test_done();
    end
  end
  // ==========================================================
  // Instances
  dma_byte_count_config dma_byte_count_config_inst (.core_clk(core_clk),
    .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .dma_req(dma_req),
    .dma_ack(dma_ack), .wide_counter_select(wide_counter_select),
    .chan_busy(chan_busy), .chan_done(chan_done));
  periph_model periph_model_inst (.core_clk(core_clk), .rstn(rstn),
    .req_en(req_en), .slow(slow), .dma_ack(dma_ack), .dma_req(dma_req),
    .ack_count(ack_count));
  // ==========================================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(exp);
    @(posedge core_clk);
    rd_en <= 1'b0;
  endtask
  // Write, then read the same slot in the very next cycle
  task automatic wr_rd(input logic [9:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    exp_q.push_back(exp);
    @(posedge core_clk);
    rd_en <= 1'b0;
  endtask
  // Two writes with the strobe held high between them
  task automatic wr2(input logic [9:0] a1, input logic [31:0] d1,
                     input logic [9:0] a2, input logic [31:0] d2);
    @(posedge core_clk);
    addr <= a1;
    wr_data <= d1;
    wr_en <= 1'b1;
    @(posedge core_clk);
    addr <= a2;
    wr_data <= d2;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // Run one transfer of n units and count the acknowledges
  task automatic run(input logic w, input logic at, input logic [23:0] n,
                     input logic [7:0] acks);
    logic [7:0] base;
    int k;
    base = ack_count;
    wr(dma_cfg_pkg::OFS_PARK, {31'h0, w});
    wr(dma_cfg_pkg::OFS_STAT, 32'h00000001);
    wr(dma_cfg_pkg::OFS_COUNT, w ? {8'h00, n} : {n[15:0], 16'h0000});
    wr(dma_cfg_pkg::OFS_CTRL, {15'h0, 1'b1, at, 15'h0});
    req_en <= 1'b1;
    for (k = 0; k < 200 && chan_done !== 1'b1; k++) @(negedge core_clk);
    req_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("ack_count", {24'h0, ack_count - base}, {24'h0, acks});
    check("chan_busy", {31'h0, chan_busy}, 32'h00000000);
    check("chan_done", {31'h0, chan_done}, 32'h00000001);
    rd(dma_cfg_pkg::OFS_STAT, 32'h00000001);
    rd(dma_cfg_pkg::OFS_COUNT, 32'h00000000);
    $display("test transfer w=%0d at=%0d done", w, at);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Read monitor: the oldest note meets the answer
  always @(posedge core_clk) rd_pend <= rd_en;
  always @(negedge core_clk) begin
    if (rd_pend) begin
      check("rd_data", rd_data, exp_q.pop_front());
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] b;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset values and an unmapped slot
    rd(dma_cfg_pkg::OFS_SRC, dma_cfg_pkg::RST_WORD);
    rd(dma_cfg_pkg::OFS_COUNT, dma_cfg_pkg::RST_WORD);
    rd(dma_cfg_pkg::OFS_VEC, dma_cfg_pkg::RST_WORD);
    rd(10'h100, 32'h00000000);
    check("wide_sel", {31'h0, wide_counter_select}, 32'h0);
    $display("test reset done");
    // Random data through the source, destination, control and both vector slots, plus an unmapped one
    repeat (4) begin
      seed = lfsr(seed);
      r = seed & 32'hFFFE7FFF;
      wr_rd(dma_cfg_pkg::OFS_SRC, r, r);
      wr_rd(dma_cfg_pkg::OFS_DST, ~r, ~r);
      wr(dma_cfg_pkg::OFS_CTRL, r);
      wr_rd(dma_cfg_pkg::OFS_VEC, r, {24'h0, r[7:0]});
      wr_rd(dma_cfg_pkg::OFS_CH2_VEC, ~r, {24'h0, ~r[7:0]});
      wr(10'h100, r);
      rd(dma_cfg_pkg::OFS_SRC, r);
      rd(dma_cfg_pkg::OFS_DST, ~r);
      rd(dma_cfg_pkg::OFS_CTRL, r);
      rd(dma_cfg_pkg::OFS_VEC, {24'h0, r[7:0]});
      rd(dma_cfg_pkg::OFS_CH2_VEC, {24'h0, ~r[7:0]});
      rd(10'h100, 32'h00000000);
    end
    wr(dma_cfg_pkg::OFS_CTRL, 32'h00000000);
    $display("test map done");
    // Legacy layout: upper half, 16 bits only
    wr(dma_cfg_pkg::OFS_COUNT, 32'h12345678);
    rd(dma_cfg_pkg::OFS_COUNT, 32'h12340000);
    // Wide layout selected as new software should
    wr(dma_cfg_pkg::OFS_PARK, 32'h00000001);
    rd(dma_cfg_pkg::OFS_PARK, 32'h00000001);
    check("wide_sel", {31'h0, wide_counter_select}, 32'h1);
    rd(dma_cfg_pkg::OFS_COUNT, 32'h00001234);
    wr(dma_cfg_pkg::OFS_COUNT, 32'hAB123456);
    rd(dma_cfg_pkg::OFS_COUNT, 32'h00123456);
    wr(dma_cfg_pkg::OFS_COUNT, 32'h00000000);
    // A start with a zero count must leave the channel idle
    wr(dma_cfg_pkg::OFS_CTRL, 32'h00010000);
    @(negedge core_clk);
    check("chan_busy", {31'h0, chan_busy}, 32'h00000000);
    $display("test layout done");
    // Ack timing: every transfer, final only, and ignored in legacy
    run(1'b1, 1'b0, 24'h000003, 8'h03);
    slow <= 1'b1;
    run(1'b1, 1'b1, 24'h000003, 8'h01);
    run(1'b0, 1'b1, 24'h000002, 8'h02);
    slow <= 1'b0;
    // Final transfer and a done clear in the same cycle: the set wins
    wr(dma_cfg_pkg::OFS_COUNT, 32'h00010000);
    req_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    b = ack_count;
    wr2(dma_cfg_pkg::OFS_CTRL, 32'h00010000,
        dma_cfg_pkg::OFS_STAT, 32'h00000001);
    repeat (2) @(posedge core_clk);
    check("chan_done", {31'h0, chan_done}, 32'h00000001);
    check("ack_count", {24'h0, ack_count - b}, 32'h00000001);
    req_en <= 1'b0;
    $display("test done priority finished");
    wr(dma_cfg_pkg::OFS_STAT, 32'h00000001);
    rd(dma_cfg_pkg::OFS_STAT, 32'h00000000);
    repeat (2) @(posedge core_clk);
    test_done();
  end
endmodule
